// *** design/fbo_image.sv ***
// controller-to-device image: ahb-lite register file and change handling
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - processing runs on own tick, not bus
// - two float inputs used as measured values
// - input values always flagged valid
// - thresholds applied when any image field changes
// - 32-bit command word triggers fixed functions
// - command word echoed back when done
// - parameter set 1 to 10 is selected
// - read request: index, subindex, ignored padding; a padding-only change still re-sends it
// - write request adds 32-bit stored value
// - index zero means no operation
// - reads of 8-, 16- and 32-bit objects
// - writes limited to 32-bit objects
// - narrow objects sit in low bits
// - commands and accesses may take many cycles
// - success needs matching index, subindex, zero error
// - float, uint16, uint8, uint32 encodings
module fbo_image
   import fbo_pkg::*;
#(
   parameter int unsigned PERIOD = PROC_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   output var  fbo_word_t   fb_val0,
   output var  fbo_word_t   fb_val1,
   output var  logic        val_upd,
   output var  logic        meas_valid,
   output var  fbo_thr_t    thr,
   output var  logic        thr_apply,
   output var  logic [15:0] dig_flags_hi,
   output var  fbo_word_t   cmd_word,
   output var  logic        cmd_req,
   input  wire logic        cmd_done,
   output var  logic [15:0] pset_sel,
   output var  logic        pset_req,
   input  wire logic        pset_ack,
   output var  fbo_od_req_s od_req,
   output var  logic        od_req_vld,
   input  wire logic        od_rsp_vld,
   input  wire fbo_od_rsp_s od_rsp
);
   typedef struct packed {
      logic [NUM_FIELDS-1:0][31:0] img;
      logic                        dp_we;
      logic [ADDR_W-1:0]           dp_addr;
      logic [31:0]                 hrdata;
      logic                        hready;
      logic                        eval;
      fbo_word_t                   val0;
      fbo_word_t                   val1;
      logic                        val_upd;
      logic                        meas_valid;
      fbo_thr_t                    thr;
      logic                        thr_apply;
      logic [15:0]                 dflags;
      fbo_word_t                   cmd_word;
      logic                        cmd_req;
      logic                        cmd_pend;
      fbo_word_t                   cmd_echo;
      logic [15:0]                 pset_sel;
      logic                        pset_req;
      logic                        pset_pend;
      logic [15:0]                 pset_act;
      logic                        rd_pend;
      logic                        wr_pend;
      logic                        od_busy;
      fbo_od_req_s                 od_req;
      logic                        od_req_vld;
      fbo_od_sel_s                 rd_sel;
      fbo_od_sel_s                 wr_sel;
      fbo_word_t                   wr_val;
      fbo_od_hdr_s                 rd_hdr;
      fbo_word_t                   rd_val;
      logic                        rd_ok;
      fbo_od_hdr_s                 wr_hdr;
      logic                        wr_ok;
   } fbo_img_s;

   fbo_img_s st_q;
   fbo_img_s st_d;

   logic                        tick;
   logic [NUM_FIELDS-1:0]       chg;
   logic [NUM_FIELDS-1:0][31:0] snap;

   // flags and set number are 16 bits wide, the rest full words
   function automatic logic [31:0] fmask(input logic [3:0] idx);
      if (idx == 4'(F_FLAGS) || idx == 4'(F_PSET)) begin
         return MASK_16;
      end
      return MASK_32;
   endfunction : fmask

   function automatic logic [31:0] szmask(input logic [1:0] sz);
      if (sz == SZ_8) begin
         return MASK_8;
      end else if (sz == SZ_16) begin
         return MASK_16;
      end
      return MASK_32;
   endfunction : szmask

   //////////////////////////////////////////////////////////////////////////
   // processing enable and per-field change detection
   fbo_tick #(
      .PERIOD (PERIOD)
   ) u_tick (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick)
   );

   // sampling on our own enable decouples processing from bus timing
   for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_fld
      fbo_chg_det #(
         .W (32)
      ) u_cd (
         .hclk    (hclk),
         .hresetn (hresetn),
         .sample  (tick),
         .din     (st_q.img[i]),
         .snap    (snap[i]),
         .changed (chg[i])
      );
   end

   //////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      fbo_od_sel_s rsel;
      fbo_od_sel_s wsel;
      logic [3:0]  widx;
      logic [3:0]  ridx;
      logic [6:0]  ra;
      rsel = snap[F_RD_REQ];
      wsel = snap[F_WR_REQ];
      widx = st_q.dp_addr[5:2];
      ra   = haddr[6:0];
      ridx = ra[5:2];
      st_d = st_q;
      st_d.val_upd    = 1'b0;
      st_d.thr_apply  = 1'b0;
      st_d.cmd_req    = 1'b0;
      st_d.pset_req   = 1'b0;
      st_d.od_req_vld = 1'b0;
      st_d.dp_we      = 1'b0;
      st_d.eval       = tick;

      // bus data phase: only image words are writable
      if (st_q.dp_we && st_q.dp_addr < A_CMD_ECHO) begin
         st_d.img[widx] = hwdata & fmask(widx);
      end

      // bus address phase; reads see a write that just landed
      if (hsel && hready && htrans[HTRANS_ACT]) begin
         st_d.dp_we   = hwrite;
         st_d.dp_addr = ra;
         st_d.hrdata  = WORD_RST;
         if (!hwrite) begin
            if (ra < A_CMD_ECHO && haddr[31:7] == '0) begin
               st_d.hrdata = st_d.img[ridx];
            end else if (haddr[31:7] != '0) begin
               st_d.hrdata = WORD_RST;
            end else if (ra == A_CMD_ECHO) begin
               st_d.hrdata = st_q.cmd_echo;
            end else if (ra == A_PSET_ACT) begin
               st_d.hrdata = {16'h0000, st_q.pset_act};
            end else if (ra == A_RD_HDR) begin
               st_d.hrdata = st_q.rd_hdr;
            end else if (ra == A_RD_VAL) begin
               st_d.hrdata = st_q.rd_val;
            end else if (ra == A_WR_HDR) begin
               st_d.hrdata = st_q.wr_hdr;
            end else if (ra == A_STATUS) begin
               st_d.hrdata[ST_RD_OK]    = st_q.rd_ok;
               st_d.hrdata[ST_WR_OK]    = st_q.wr_ok;
               st_d.hrdata[ST_RD_PEND]  = st_q.rd_pend;
               st_d.hrdata[ST_WR_PEND]  = st_q.wr_pend;
               st_d.hrdata[ST_OD_BUSY]  = st_q.od_busy;
               st_d.hrdata[ST_CMD_PEND] = st_q.cmd_pend;
               st_d.hrdata[ST_MEAS_OK]  = st_q.meas_valid;
               st_d.hrdata[ST_PSET_PND] = st_q.pset_pend;
            end
         end
      end

      // completions first so a fresh change in the same cycle wins
      if (cmd_done && st_q.cmd_pend) begin
         st_d.cmd_echo = st_q.cmd_word;
         st_d.cmd_pend = 1'b0;
      end
      if (pset_ack && st_q.pset_pend) begin
         st_d.pset_act  = st_q.pset_sel;
         st_d.pset_pend = 1'b0;
      end
      if (od_rsp_vld && st_q.od_busy) begin
         st_d.od_busy = 1'b0;
         if (st_q.od_req.we) begin
            st_d.wr_hdr = od_rsp.hdr;
            st_d.wr_ok  = od_rsp.hdr.index == st_q.od_req.sel.index &&
                          od_rsp.hdr.sub == st_q.od_req.sel.sub &&
                          od_rsp.hdr.err == ERR_NONE;
         end else begin
            st_d.rd_hdr = od_rsp.hdr;
            st_d.rd_val = od_rsp.value & szmask(od_rsp.size);
            st_d.rd_ok  = od_rsp.hdr.index == st_q.od_req.sel.index &&
                          od_rsp.hdr.sub == st_q.od_req.sel.sub &&
                          od_rsp.hdr.err == ERR_NONE;
         end
      end

      // dispatch one dictionary access at a time, reads first
      if (!st_q.od_busy && (st_q.rd_pend || st_q.wr_pend)) begin
         st_d.od_busy    = 1'b1;
         st_d.od_req_vld = 1'b1;
         if (st_q.rd_pend) begin
            st_d.rd_pend      = 1'b0;
            st_d.od_req.we    = 1'b0;
            st_d.od_req.sel   = st_q.rd_sel;
            st_d.od_req.wdata = WORD_RST;
         end else begin
            st_d.wr_pend      = 1'b0;
            st_d.od_req.we    = 1'b1;
            st_d.od_req.sel   = st_q.wr_sel;
            st_d.od_req.wdata = st_q.wr_val;
         end
      end

      // evaluation one cycle after the snapshot
      if (st_q.eval) begin
         st_d.val0    = snap[F_VAL0];
         st_d.val1    = snap[F_VAL1];
         st_d.val_upd = 1'b1;
         if (|chg) begin
            st_d.thr       = snap[F_THR0 +: NUM_THR];
            st_d.thr_apply = 1'b1;
         end
         if (chg[F_FLAGS]) begin
            st_d.dflags = snap[F_FLAGS][15:0];
         end
         if (chg[F_CTRL]) begin
            st_d.cmd_word = snap[F_CTRL];
            st_d.cmd_req  = 1'b1;
            st_d.cmd_pend = 1'b1;
         end
         // out-of-range numbers still count as a change, no switch
         if (chg[F_PSET] && snap[F_PSET][15:0] >= PSET_MIN &&
             snap[F_PSET][15:0] <= PSET_MAX) begin
            st_d.pset_sel  = snap[F_PSET][15:0];
            st_d.pset_req  = 1'b1;
            st_d.pset_pend = 1'b1;
         end
         // request kept at change time: a later index zero is never sent
         if (chg[F_RD_REQ] && rsel.index != OD_NOP) begin
            st_d.rd_pend = 1'b1;
            st_d.rd_sel  = rsel;
         end
         if ((chg[F_WR_REQ] || chg[F_WR_VAL]) && wsel.index != OD_NOP) begin
            st_d.wr_pend = 1'b1;
            st_d.wr_sel  = wsel;
            st_d.wr_val  = snap[F_WR_VAL];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q            <= '0;
         st_q.hready     <= 1'b1;
         st_q.meas_valid <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs
   assign hreadyout    = st_q.hready;
   assign hresp        = 1'b0;
   assign hrdata       = st_q.hrdata;
   assign fb_val0      = st_q.val0;
   assign fb_val1      = st_q.val1;
   assign val_upd      = st_q.val_upd;
   assign meas_valid   = st_q.meas_valid;
   assign thr          = st_q.thr;
   assign thr_apply    = st_q.thr_apply;
   assign dig_flags_hi = st_q.dflags;
   assign cmd_word     = st_q.cmd_word;
   assign cmd_req      = st_q.cmd_req;
   assign pset_sel     = st_q.pset_sel;
   assign pset_req     = st_q.pset_req;
   assign od_req       = st_q.od_req;
   assign od_req_vld   = st_q.od_req_vld;

   //////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_val_refresh: assert property (tick |-> ##2 (val_upd &&
      fb_val0 == $past(st_q.img[F_VAL0], 2)))
      else $error("input value not refreshed from image");
   a_meas_valid: assert property (val_upd |-> meas_valid)
      else $error("input values not marked valid");
   a_thr_only_chg: assert property (thr_apply |->
      $past(st_q.eval) && $past(|chg))
      else $error("threshold applied without a change");
   a_thr_any_chg: assert property (st_q.eval && |chg |=>
      thr_apply && thr == $past(snap[F_THR0 +: NUM_THR]))
      else $error("thresholds not reapplied on change");
   a_flags_copy: assert property (st_q.eval && chg[F_FLAGS] |=>
      dig_flags_hi == $past(snap[F_FLAGS][15:0]))
      else $error("flags not copied");
   a_cmd_echo: assert property (cmd_done && st_q.cmd_pend |=>
      st_q.cmd_echo == $past(cmd_word))
      else $error("command echo wrong");
   a_pset_range: assert property (pset_req |->
      pset_sel >= PSET_MIN && pset_sel <= PSET_MAX)
      else $error("parameter set out of range");
   a_pset_chg: assert property (pset_req |->
      $past(st_q.eval) && $past(chg[F_PSET]))
      else $error("parameter set acted on without change");
   a_od_nop: assert property (od_req_vld |->
      od_req.sel.index != OD_NOP)
      else $error("dictionary access with index zero");
   a_od_dispatch: assert property ((st_q.rd_pend || st_q.wr_pend) &&
      !st_q.od_busy |=> od_req_vld ##1 !od_req_vld)
      else $error("pending access not dispatched");
   a_rd_ok: assert property (od_rsp_vld && st_q.od_busy &&
      !od_req.we && od_rsp.hdr.err != ERR_NONE |=> !st_q.rd_ok)
      else $error("read marked ok despite error");

   c_thr_apply: cover property (thr_apply);
   c_od_read: cover property (od_req_vld && !od_req.we ##[1:50] od_rsp_vld);
   c_od_write: cover property (od_req_vld && od_req.we ##[1:50] od_rsp_vld);
   c_cmd_echo: cover property (cmd_req ##[1:50] (cmd_done && st_q.cmd_pend));
endmodule : fbo_image
`default_nettype wire

// *** design/fbo_pkg.sv ***
// shared constants and carrier types of the fieldbus output image handler
`default_nettype none
package fbo_pkg;
   // clock and processing period
   localparam int unsigned CLK_PERIOD_NS  = 8;
   localparam int unsigned PROC_PERIOD_NS = 1000000;
   localparam int unsigned PROC_CYCLES    =
      (PROC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // image word positions, one aligned bus word each
   localparam int NUM_FIELDS = 12;
   localparam int F_VAL0     = 0;
   localparam int F_VAL1     = 1;
   localparam int F_THR0     = 2;
   localparam int NUM_THR    = 4;
   localparam int F_FLAGS    = 6;
   localparam int F_CTRL     = 7;
   localparam int F_PSET     = 8;
   localparam int F_RD_REQ   = 9;
   localparam int F_WR_REQ   = 10;
   localparam int F_WR_VAL   = 11;

   // byte addresses of the register file
   localparam int       ADDR_W     = 7;
   localparam logic [6:0] A_CMD_ECHO = 7'h30;
   localparam logic [6:0] A_PSET_ACT = 7'h34;
   localparam logic [6:0] A_RD_HDR   = 7'h38;
   localparam logic [6:0] A_RD_VAL   = 7'h3c;
   localparam logic [6:0] A_WR_HDR   = 7'h40;
   localparam logic [6:0] A_STATUS   = 7'h44;

   // status register bit positions
   localparam int ST_RD_OK    = 0;
   localparam int ST_WR_OK    = 1;
   localparam int ST_RD_PEND  = 2;
   localparam int ST_WR_PEND  = 3;
   localparam int ST_OD_BUSY  = 4;
   localparam int ST_CMD_PEND = 5;
   localparam int ST_MEAS_OK  = 6;
   localparam int ST_PSET_PND = 7;

   // field widths and masks
   localparam logic [31:0] MASK_8   = 32'h0000_00ff;
   localparam logic [31:0] MASK_16  = 32'h0000_ffff;
   localparam logic [31:0] MASK_32  = 32'hffff_ffff;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [15:0] PSET_MIN = 16'h0001;
   localparam logic [15:0] PSET_MAX = 16'h000a;
   localparam logic [15:0] OD_NOP   = 16'h0000;
   localparam logic [7:0]  ERR_NONE = 8'h00;
   localparam logic [1:0]  SZ_8     = 2'h1;
   localparam logic [1:0]  SZ_16    = 2'h2;
   localparam int          HTRANS_ACT = 1;

   typedef logic [31:0]                fbo_word_t;
   typedef logic [NUM_THR-1:0][31:0]   fbo_thr_t;

   // request selector word: index low, subindex, padding high
   typedef struct packed {
      logic [7:0]  pad;
      logic [7:0]  sub;
      logic [15:0] index;
   } fbo_od_sel_s;

   // response header word: index low, subindex, error high
   typedef struct packed {
      logic [7:0]  err;
      logic [7:0]  sub;
      logic [15:0] index;
   } fbo_od_hdr_s;

   typedef struct packed {
      logic        we;
      fbo_od_sel_s sel;
      fbo_word_t   wdata;
   } fbo_od_req_s;

   typedef struct packed {
      fbo_od_hdr_s hdr;
      logic [1:0]  size;
      fbo_word_t   value;
   } fbo_od_rsp_s;
endpackage : fbo_pkg
`default_nettype wire

// *** design/fbo_tick.sv ***
// processing-rate enable divider, independent of any fieldbus cycle
`default_nettype none
module fbo_tick
   import fbo_pkg::*;
#(
   parameter int unsigned PERIOD = PROC_CYCLES
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   output var  logic tick
);
   localparam int CW = $clog2(PERIOD + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(PERIOD - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } fbo_tick_s;

   fbo_tick_s st_q;
   fbo_tick_s st_d;

   always_comb begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (st_q.cnt == CNT_LAST) begin
         st_d.cnt  = '0;
         st_d.tick = 1'b1;
      end else begin
         st_d.cnt = st_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick = st_q.tick;
endmodule : fbo_tick
`default_nettype wire

// *** design/fbo_chg_det.sv ***
// one image field: snapshot on the processing enable and change flag
`default_nettype none
module fbo_chg_det #(
   parameter int W = 32
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         sample,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] snap,
   output var  logic         changed
);
   typedef struct packed {
      logic [W-1:0] snap;
      logic         changed;
   } fbo_cd_s;

   fbo_cd_s st_q;
   fbo_cd_s st_d;

   always_comb begin
      st_d         = st_q;
      st_d.changed = 1'b0;
      if (sample) begin
         st_d.changed = (din != st_q.snap);
         st_d.snap    = din;
      end
   end

   // copies start cleared so a zero image is no change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign snap    = st_q.snap;
   assign changed = st_q.changed;
endmodule : fbo_chg_det
`default_nettype wire

// *** verif/fbo_far_model.sv ***
// function unit and object dictionary model facing the image handler
`default_nettype none
module fbo_far_model
   import fbo_pkg::*;
#(
   parameter int DLY = 20
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        cmd_req,
   output var  logic        cmd_done,
   input  wire logic        pset_req,
   output var  logic        pset_ack,
   input  wire fbo_od_req_s od_req,
   input  wire logic        od_req_vld,
   output var  logic        od_rsp_vld,
   output var  fbo_od_rsp_s od_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   int          cmd_cnt;
   int          pset_cnt;
   int          od_cnt;
   fbo_od_req_s req_q;
   fbo_word_t   mem [16];

   // slow on purpose: completion well past one processing tick
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_done   <= 1'b0;
         pset_ack   <= 1'b0;
         od_rsp_vld <= 1'b0;
         od_rsp     <= '0;
         cmd_cnt    <= 0;
         pset_cnt   <= 0;
         od_cnt     <= 0;
      end else begin
         if (cmd_req) cmd_cnt <= DLY;
         else if (cmd_cnt != 0) cmd_cnt <= cmd_cnt - 1;
         cmd_done <= (cmd_cnt == 1);
         if (pset_req) pset_cnt <= DLY;
         else if (pset_cnt != 0) pset_cnt <= pset_cnt - 1;
         pset_ack <= (pset_cnt == 1);
         if (od_req_vld) begin
            req_q  <= od_req;
            od_cnt <= DLY;
         end else if (od_cnt != 0) begin
            od_cnt <= od_cnt - 1;
         end
         od_rsp_vld <= (od_cnt == 1);
         if (od_cnt == 1) begin
            od_rsp.hdr <= {ERR_NONE, req_q.sel.sub, req_q.sel.index};
            // size taken from subindex low bits
            od_rsp.size <= req_q.sel.sub[1:0];
            if (req_q.we) begin
               mem[req_q.sel.index[3:0]] <= req_q.wdata;
               od_rsp.value <= req_q.wdata;
            end else begin
               od_rsp.value <= mem[req_q.sel.index[3:0]];
            end
         end else begin
            // stale response must not look valid
            od_rsp <= ~od_rsp;
         end
      end
   end
endmodule : fbo_far_model
`default_nettype wire

// *** verif/fbo_image_test.sv ***
// self-checking bench of the controller-to-device image handler
`default_nettype none
module fbo_image_test
   import fbo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 8;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rdat;
   logic [1:0] htrans = '0;
   logic hreadyout, hresp, val_upd, meas_valid, thr_apply;
   logic cmd_req, cmd_done, pset_req, pset_ack, od_req_vld, od_rsp_vld;
   fbo_word_t fb_val0, fb_val1, cmd_word;
   fbo_thr_t thr;
   logic [15:0] dig_flags_hi, pset_sel;
   fbo_od_req_s od_req;
   fbo_od_rsp_s od_rsp;
   int errors = 0, check_count = 0, cyc = 0, n_thr = 0, n_ps = 0, n_od = 0;
   int n;
   logic [15:0] pv [5] = '{16'h1, 16'ha, 16'ha, 16'hb, 16'ha};
   int          pi [5] = '{1, 1, 0, 0, 1};

   fbo_image #(.PERIOD(P)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .fb_val0(fb_val0), .fb_val1(fb_val1),
      .val_upd(val_upd), .meas_valid(meas_valid), .thr(thr),
      .thr_apply(thr_apply), .dig_flags_hi(dig_flags_hi),
      .cmd_word(cmd_word), .cmd_req(cmd_req), .cmd_done(cmd_done),
      .pset_sel(pset_sel), .pset_req(pset_req), .pset_ack(pset_ack),
      .od_req(od_req), .od_req_vld(od_req_vld), .od_rsp_vld(od_rsp_vld),
      .od_rsp(od_rsp));
   fbo_far_model #(.DLY(20)) far (.hclk(hclk), .hresetn(hresetn),
      .cmd_req(cmd_req), .cmd_done(cmd_done), .pset_req(pset_req),
      .pset_ack(pset_ack), .od_req(od_req), .od_req_vld(od_req_vld),
      .od_rsp_vld(od_rsp_vld), .od_rsp(od_rsp));

   always #4 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (thr_apply === 1'b1) n_thr <= n_thr + 1;
      if (pset_req === 1'b1) n_ps <= n_ps + 1;
      if (od_req_vld === 1'b1) n_od <= n_od + 1;
      if (cyc == 20000) begin
         errors++;
         conclude();
      end
   end

   task automatic conclude();
      if (errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one single transfer; waits on hready in both phases
   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : xfer

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, '0);
      chk(rdat, exp);
   endtask : rd

   // two ticks plus the evaluation latency
   task automatic settle();
      repeat (2 * P + 4) @(posedge hclk);
   endtask : settle

   task automatic wait_idle();
      int k;
      settle();
      for (k = 0; k < 100; k++) begin
         xfer({25'h0, A_STATUS}, 1'b0, '0);
         if ((rdat & 32'hbc) === 32'h0) break;
      end
      if (k == 100) chk(rdat & 32'hbc, 32'h0);
   endtask : wait_idle

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rd({25'h0, A_STATUS}, 32'h40);
      rd({25'h0, A_CMD_ECHO}, 32'h0);
      rd(32'h48, 32'h0);
      wr(32'h00, 32'h3f80_0000);
      wr(32'h04, 32'hc020_0000);
      wr(32'h08, 32'h4000_0000);
      wr(32'h14, 32'h4120_0000);
      settle();
      chk(fb_val0, 32'h3f80_0000);
      chk(fb_val1, 32'hc020_0000);
      chk({31'h0, meas_valid}, 32'h1);
      chk(thr[3], 32'h4120_0000);
      chk(thr[0], 32'h4000_0000);
      n = n_thr;
      wr(32'h18, 32'h0000_a5c3);
      settle();
      chk({16'h0, dig_flags_hi}, 32'h0000_a5c3);
      chk(n_thr, n + 1);
      chk(thr[3], 32'h4120_0000);
      wr(32'h1c, 32'h8000_0001);
      settle();
      chk(cmd_word, 32'h8000_0001);
      wait_idle();
      rd({25'h0, A_CMD_ECHO}, 32'h8000_0001);
      for (int i = 0; i < 5; i++) begin
         n = n_ps;
         wr(32'h20, {16'h0, pv[i]});
         wait_idle();
         chk(n_ps, n + pi[i]);
      end
      chk({16'h0, pset_sel}, 32'h0000_000a);
      rd({25'h0, A_PSET_ACT}, 32'h0000_000a);
      wr(32'h2c, 32'h1234_5678);
      wr(32'h28, 32'h0003_0002);
      wait_idle();
      rd({25'h0, A_STATUS}, 32'h42);
      rd({25'h0, A_WR_HDR}, 32'h0003_0002);
      chk({31'h0, hresp}, 32'h0);
      for (int s = 1; s < 4; s++) begin
         wr(32'h24, {8'h00, 8'(s), 16'h0002});
         wait_idle();
         rd({25'h0, A_RD_HDR}, {8'h00, 8'(s), 16'h0002});
         rd({25'h0, A_RD_VAL}, s == 1 ? 32'h78 :
            s == 2 ? 32'h5678 : 32'h1234_5678);
      end
      n = n_od;
      wr(32'h24, 32'h0003_0002);
      wait_idle();
      chk(n_od, n);
      wr(32'h24, 32'h0003_0000);
      wait_idle();
      chk(n_od, n);
      wr(32'h24, 32'h0003_0002);
      wait_idle();
      chk(n_od, n + 1);
      wr(32'h24, 32'h0103_0002);
      wait_idle();
      chk(n_od, n + 2);
      rd({25'h0, A_STATUS}, 32'h43);
      conclude();
   end
endmodule : fbo_image_test
`default_nettype wire
